// ==== logic/otp_gen.sv ====
// output test pattern selector that sits between converter and output lanes
`timescale 1ns/1ns
`include "otp_consts.svh"

// What this block does
// - mode field in register output_test_mode_select; 0000 at reset passes converted samples.
// - mode 0001 sends midscale zero on every sample.
// - mode 0010 sends positive full scale on every sample.
// - mode 0011 sends negative full scale on every sample.
// - mode 0100 alternates checkerboard words, never format converted.
// - mode 0101 sends a long pseudorandom sequence, format converted.
// - mode 0111 alternates all ones and all zeros, never format converted.
// - mode 1000 sends user words from registers user_pattern_first to user_pattern_last, format converted.
// - mode 1111 sends a ramp rising by one per sample, never format converted.
module otp_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [12:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // output format select, high for offset binary
    input wire logic fmt_offset_bin,
    // converted samples in
    input wire logic smp_valid,
    input wire logic [11:0] smp_data,
    // samples to the output lanes
    output logic out_valid,
    output logic [11:0] out_data
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] mode_reg_ff;
    logic [7:0] user_mem [0:`OTP_USER_BYTES-1];
    logic [7:0] rdata_ff;
    logic mode_wr;
    logic user_hit;
    logic [12:0] user_off;
    otp_pkg::otp_mode_t mode;

    assign mode_wr = reg_wr && (reg_addr == `OTP_ADDR_MODE);
    assign user_hit = (reg_addr >= `OTP_ADDR_USER_FIRST) && (reg_addr <= `OTP_ADDR_USER_LAST);
    assign user_off = reg_addr - `OTP_ADDR_USER_FIRST;
    assign mode = otp_pkg::otp_mode_t'(mode_reg_ff[3:0]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg_ff <= `OTP_MODE_RST;
        end else if (mode_wr) begin
            mode_reg_ff <= reg_wdata;
        end
    end

    // user bytes carry no reset, as a plain pattern store would
    always_ff @(posedge core_clk) begin
        if (reg_wr && user_hit) begin
            user_mem[user_off[2:0]] <= reg_wdata;
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_ff <= `OTP_RDATA_RST;
        end else if (reg_rd) begin
            if (reg_addr == `OTP_ADDR_MODE) begin
                rdata_ff <= mode_reg_ff;
            end else if (user_hit) begin
                rdata_ff <= user_mem[user_off[2:0]];
            end else begin
                rdata_ff <= `OTP_RDATA_RST;
            end
        end
    end

    assign reg_rdata = rdata_ff;

    // ************************************************************
    // pattern sequencing
    // ************************************************************
    // a mode write restarts every sequence so word 1 always comes first
    logic phase_ff;
    logic [11:0] ramp_ff;
    logic [1:0] user_idx_ff;
    logic [11:0] pn_word;
    logic [11:0] user_word [0:`OTP_USER_WORDS-1];

    always_ff @(posedge core_clk) begin
        if (rst || mode_wr) begin
            phase_ff <= 1'b0;
        end else if (smp_valid) begin
            phase_ff <= ~phase_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || mode_wr) begin
            ramp_ff <= `OTP_DATA_RST;
        end else if (smp_valid && mode == otp_pkg::OTP_RAMP) begin
            ramp_ff <= ramp_ff + `OTP_RAMP_STEP;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || mode_wr) begin
            user_idx_ff <= `OTP_USER_IDX_RST;
        end else if (smp_valid && mode == otp_pkg::OTP_USER) begin
            user_idx_ff <= user_idx_ff + `OTP_USER_IDX_STEP;
        end
    end

    // odd byte holds the upper eight bits, even byte's top nibble the rest
    genvar gi;
    generate
        for (gi = 0; gi < `OTP_USER_WORDS; gi = gi + 1) begin : g_user
            assign user_word[gi] = {user_mem[2*gi+1], user_mem[2*gi][7:4]};
        end
    endgenerate

    otp_pn_gen u_pn (
        .core_clk(core_clk),
        .rst(rst),
        .pn_restart(mode_wr),
        .pn_advance(smp_valid && mode == otp_pkg::OTP_PN),
        .pn_word(pn_word)
    );

    // ************************************************************
    // word selection and format conversion
    // ************************************************************
    logic [11:0] nxt_word;
    logic nxt_conv;

    always_comb begin
        nxt_word = smp_data;
        nxt_conv = 1'b1;
        unique case (mode)
            otp_pkg::OTP_OFF: nxt_word = smp_data;
            otp_pkg::OTP_MID: nxt_word = `OTP_MIDSCALE;
            otp_pkg::OTP_POS: nxt_word = `OTP_POS_FS;
            otp_pkg::OTP_NEG: nxt_word = `OTP_NEG_FS;
            otp_pkg::OTP_CHK: begin
                nxt_word = phase_ff ? `OTP_CHK_B : `OTP_CHK_A;
                nxt_conv = 1'b0;
            end
            otp_pkg::OTP_PN: nxt_word = pn_word;
            otp_pkg::OTP_TGL: begin
                nxt_word = phase_ff ? `OTP_ALL_ZERO : `OTP_ALL_ONE;
                nxt_conv = 1'b0;
            end
            otp_pkg::OTP_USER: nxt_word = user_word[user_idx_ff];
            otp_pkg::OTP_RAMP: begin
                nxt_word = ramp_ff;
                nxt_conv = 1'b0;
            end
            default: nxt_word = smp_data;
        endcase
    end

    // offset binary differs from twos complement only in the sign bit
    logic [11:0] out_data_ff;
    logic out_valid_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_data_ff <= `OTP_DATA_RST;
        end else if (smp_valid) begin
            out_data_ff <= (nxt_conv && fmt_offset_bin) ? nxt_word ^ `OTP_FMT_FLIP
                                                        : nxt_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_valid_ff <= 1'b0;
        end else begin
            out_valid_ff <= smp_valid;
        end
    end

    assign out_data = out_data_ff;
    assign out_valid = out_valid_ff;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [11:0] fmt_mask;
    assign fmt_mask = fmt_offset_bin ? `OTP_FMT_FLIP : `OTP_DATA_RST;

    a_off_passthru: assert property (
        smp_valid && !mode_wr && mode == otp_pkg::OTP_OFF
        |=> out_valid && out_data == ($past(smp_data) ^ $past(fmt_mask)))
        else $error("off mode did not pass the sample");
    a_midscale_word: assert property (
        smp_valid && mode == otp_pkg::OTP_MID
        |=> out_data == (`OTP_MIDSCALE ^ $past(fmt_mask)))
        else $error("midscale word wrong");
    a_pos_full: assert property (
        smp_valid && mode == otp_pkg::OTP_POS
        |=> out_data == (`OTP_POS_FS ^ $past(fmt_mask)))
        else $error("positive full scale wrong");
    a_neg_full: assert property (
        smp_valid && mode == otp_pkg::OTP_NEG
        |=> out_data == (`OTP_NEG_FS ^ $past(fmt_mask)))
        else $error("negative full scale wrong");
    a_checker_alt: assert property (
        (smp_valid && !mode_wr && mode == otp_pkg::OTP_CHK) ##1
        (smp_valid && !mode_wr && mode == otp_pkg::OTP_CHK)
        |=> (out_data == `OTP_CHK_A || out_data == `OTP_CHK_B) && out_data == ~$past(out_data))
        else $error("checkerboard did not alternate");
    a_pn_format: assert property (
        smp_valid && mode == otp_pkg::OTP_PN
        |=> out_data == ($past(pn_word) ^ $past(fmt_mask)))
        else $error("pseudorandom word wrong");
    a_toggle_alt: assert property (
        (smp_valid && !mode_wr && mode == otp_pkg::OTP_TGL) ##1
        (smp_valid && !mode_wr && mode == otp_pkg::OTP_TGL)
        |=> (out_data == `OTP_ALL_ONE || out_data == `OTP_ALL_ZERO)
            && out_data == ~$past(out_data))
        else $error("one zero toggle did not alternate");
    a_user_word: assert property (
        smp_valid && mode == otp_pkg::OTP_USER
        |=> out_data == ($past(user_word[user_idx_ff]) ^ $past(fmt_mask)))
        else $error("user word wrong");
    a_ramp_step: assert property (
        (smp_valid && !mode_wr && mode == otp_pkg::OTP_RAMP) ##1
        (smp_valid && !mode_wr && mode == otp_pkg::OTP_RAMP)
        |=> out_data == $past(out_data) + `OTP_RAMP_STEP)
        else $error("ramp did not step by one");
    a_bypass_fmt: assert property (
        smp_valid && fmt_offset_bin && mode == otp_pkg::OTP_CHK
        |=> out_data == `OTP_CHK_A || out_data == `OTP_CHK_B)
        else $error("bypass pattern was format converted");
    a_unlisted_off: assert property (
        smp_valid && mode_reg_ff[3:0] == 4'h6
        |=> out_data == ($past(smp_data) ^ $past(fmt_mask)))
        else $error("unlisted mode did not pass the sample");

    c_mode_write: cover property (mode_wr ##1 smp_valid [*2]);
    c_ramp_run: cover property ((smp_valid && mode == otp_pkg::OTP_RAMP) [*4]);
    c_user_wrap: cover property (smp_valid && mode == otp_pkg::OTP_USER && user_idx_ff == 2'h3);
    c_pn_offset: cover property (smp_valid && fmt_offset_bin && mode == otp_pkg::OTP_PN);
endmodule

// ==== inc/otp_consts.svh ====
// constants for the output test pattern generator
`ifndef OTP_CONSTS_SVH
`define OTP_CONSTS_SVH

// ************************************************************
// register map
// ************************************************************
`define OTP_ADDR_MODE 13'h00D
`define OTP_ADDR_USER_FIRST 13'h019
`define OTP_ADDR_USER_LAST 13'h020
`define OTP_MODE_RST 8'h00
`define OTP_RDATA_RST 8'h00

// ************************************************************
// fixed pattern words, twos complement
// ************************************************************
`define OTP_MIDSCALE 12'h000
`define OTP_POS_FS 12'h7FF
`define OTP_NEG_FS 12'h800
`define OTP_CHK_A 12'hAAA
`define OTP_CHK_B 12'h555
`define OTP_ALL_ONE 12'hFFF
`define OTP_ALL_ZERO 12'h000
`define OTP_FMT_FLIP 12'h800
`define OTP_RAMP_STEP 12'h001
`define OTP_DATA_RST 12'h000

// ************************************************************
// user pattern and pseudorandom source
// ************************************************************
`define OTP_USER_BYTES 8
`define OTP_USER_WORDS 4
`define OTP_USER_IDX_RST 2'h0
`define OTP_USER_IDX_STEP 2'h1
`define OTP_PN_SEED 23'h7FFFFF
`define OTP_PN_TAP_A 22
`define OTP_PN_TAP_B 17

`endif

// ==== inc/otp_pkg.sv ====
// types for the output test pattern generator
package otp_pkg;
    typedef enum logic [3:0] {
        OTP_OFF = 4'b0000,
        OTP_MID = 4'b0001,
        OTP_POS = 4'b0010,
        OTP_NEG = 4'b0011,
        OTP_CHK = 4'b0100,
        OTP_PN = 4'b0101,
        OTP_TGL = 4'b0111,
        OTP_USER = 4'b1000,
        OTP_RAMP = 4'b1111
    } otp_mode_t;
endpackage

// ==== logic/otp_pn_gen.sv ====
// pseudorandom word source for the pattern generator
`timescale 1ns/1ns
`include "otp_consts.svh"

module otp_pn_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic pn_restart,
    input wire logic pn_advance,
    // word out
    output logic [11:0] pn_word
);
    logic [22:0] lfsr_ff;

    // one shift per sample keeps the logic small; words overlap by eleven bits
    always_ff @(posedge core_clk) begin
        if (rst || pn_restart) begin
            lfsr_ff <= `OTP_PN_SEED;
        end else if (pn_advance) begin
            lfsr_ff <= {lfsr_ff[21:0], lfsr_ff[`OTP_PN_TAP_A] ^ lfsr_ff[`OTP_PN_TAP_B]};
        end
    end

    assign pn_word = lfsr_ff[11:0];
endmodule

// ==== verif/otp_lane_rx.sv ====
// receiver model that stands on the output lanes of the pattern generator
`timescale 1ns/1ns

module otp_lane_rx (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // words from the generator
    input wire logic out_valid,
    input wire logic [11:0] out_data,
    // what was received
    output logic [15:0] rx_count,
    output logic [11:0] rx_last
);
    // no back-pressure on the lanes, so every valid word is taken
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_count <= 16'h0000;
            rx_last <= 12'h000;
        end else if (out_valid) begin
            rx_count <= rx_count + 16'h0001;
            rx_last <= out_data;
        end
    end
endmodule

// ==== verif/otp_gen_tb_top.sv ====
// self-checking testbench for the output test pattern generator
`timescale 1ns/1ns
`include "otp_consts.svh"

module otp_gen_tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [12:0] reg_addr = 13'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic fmt_offset_bin = 1'b0;
    logic smp_valid = 1'b0;
    logic [11:0] smp_data = 12'h000;
    logic out_valid;
    logic [11:0] out_data;
    logic [15:0] rx_count;
    logic [11:0] rx_last;
    logic [11:0] flip;
    logic [11:0] pn_a [8];
    logic [7:0] ub [8];
    int err_count = 0;
    int n_compared = 0;
    int n_sent = 0;

    always #5 core_clk = ~core_clk;

    otp_gen dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .fmt_offset_bin(fmt_offset_bin), .smp_valid(smp_valid), .smp_data(smp_data),
        .out_valid(out_valid), .out_data(out_data));
    otp_lane_rx rx (.core_clk(core_clk), .rst(rst), .out_valid(out_valid),
        .out_data(out_data), .rx_count(rx_count), .rx_last(rx_last));

    // ************************************************************
    // compare and bus tasks
    // ************************************************************
    task automatic cmp_word(string what, logic [11:0] exp, logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_byte(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [12:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [12:0] a, logic [7:0] exp, string what);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp_byte(what, exp, reg_rdata);
    endtask
    // out_data is looked at one cycle after the sample is driven
    task automatic smp(logic [11:0] d, logic [11:0] exp, string what, bit chk = 1'b1);
        @(posedge core_clk);
        smp_valid <= 1'b1;
        smp_data <= d;
        @(posedge core_clk);
        smp_valid <= 1'b0;
        n_sent++;
        #1 cmp_byte("out_valid", 8'h01, {7'h00, out_valid});
        if (chk) cmp_word(what, exp, out_data);
    endtask
    // back-to-back samples with valid held high, so the alternation checks see pairs
    task automatic burst(logic [11:0] e0, logic [11:0] e1, logic [11:0] e2, logic [11:0] e3,
                         string what);
        logic [11:0] e [4];
        e = '{e0, e1, e2, e3};
        @(posedge core_clk);
        smp_valid <= 1'b1;
        smp_data <= 12'h111;
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            if (k == 3) smp_valid <= 1'b0;
            n_sent++;
            #1 cmp_byte("out_valid", 8'h01, {7'h00, out_valid});
            cmp_word(what, e[k], out_data);
        end
    endtask
    task automatic set_fmt(bit f);
        @(posedge core_clk);
        fmt_offset_bin <= f;
        flip = f ? `OTP_FMT_FLIP : 12'h000;
    endtask
    task automatic mode(otp_pkg::otp_mode_t m);
        wr(`OTP_ADDR_MODE, {4'h0, m});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rd(`OTP_ADDR_MODE, `OTP_MODE_RST, "mode at reset");
        rd(13'h001, 8'h00, "unmapped read");
        smp(12'h123, 12'h123, "off sample");
        set_fmt(1'b1);
        smp(12'h123, 12'h923, "off offset binary");
        wr(`OTP_ADDR_MODE, 8'hF0);
        rd(`OTP_ADDR_MODE, 8'hF0, "mode upper bits");
        smp(12'h456, 12'hC56, "off with upper bits");
        $display("test reset done");
    endtask
    task automatic t_fixed();
        for (int f = 0; f < 2; f++) begin
            set_fmt(f[0]);
            mode(otp_pkg::OTP_MID);
            smp(12'h3C5, `OTP_MIDSCALE ^ flip, "midscale w1");
            smp(12'h3C5, `OTP_MIDSCALE ^ flip, "midscale w2");
            mode(otp_pkg::OTP_POS);
            smp(12'h3C5, `OTP_POS_FS ^ flip, "pos fs w1");
            smp(12'h3C5, `OTP_POS_FS ^ flip, "pos fs w2");
            mode(otp_pkg::OTP_NEG);
            smp(12'h3C5, `OTP_NEG_FS ^ flip, "neg fs w1");
            smp(12'h3C5, `OTP_NEG_FS ^ flip, "neg fs w2");
        end
        $display("test fixed done");
    endtask
    task automatic t_alt();
        set_fmt(1'b1);
        mode(otp_pkg::OTP_CHK);
        smp(12'h111, `OTP_CHK_A, "checker w1");
        smp(12'h111, `OTP_CHK_B, "checker w2");
        smp(12'h111, `OTP_CHK_A, "checker w3");
        mode(otp_pkg::OTP_CHK);
        burst(`OTP_CHK_A, `OTP_CHK_B, `OTP_CHK_A, `OTP_CHK_B, "checker run");
        mode(otp_pkg::OTP_TGL);
        smp(12'h111, `OTP_ALL_ONE, "toggle w1");
        smp(12'h111, `OTP_ALL_ZERO, "toggle w2");
        smp(12'h111, `OTP_ALL_ONE, "toggle w3");
        mode(otp_pkg::OTP_TGL);
        burst(`OTP_ALL_ONE, `OTP_ALL_ZERO, `OTP_ALL_ONE, `OTP_ALL_ZERO, "toggle run");
        mode(otp_pkg::OTP_TGL);
        smp(12'h111, `OTP_ALL_ONE, "toggle restart");
        $display("test alternating done");
    endtask
    task automatic t_ramp();
        set_fmt(1'b1);
        mode(otp_pkg::OTP_RAMP);
        for (int i = 0; i < 5; i++) smp(12'h7F0, 12'(i), "ramp");
        mode(otp_pkg::OTP_RAMP);
        smp(12'h7F0, 12'h000, "ramp restart");
        mode(otp_pkg::OTP_RAMP);
        burst(12'h000, 12'h001, 12'h002, 12'h003, "ramp run");
        $display("test ramp done");
    endtask
    task automatic t_user();
        for (int i = 0; i < 8; i++) ub[i] = 8'h1F + 8'(i) * 8'h2D;
        for (int i = 0; i < 8; i++) wr(`OTP_ADDR_USER_FIRST + 13'(i), ub[i]);
        rd(`OTP_ADDR_USER_LAST, ub[7], "user last byte");
        set_fmt(1'b1);
        mode(otp_pkg::OTP_USER);
        for (int k = 0; k < 5; k++)
            smp(12'h000, {ub[2 * (k % 4) + 1], ub[2 * (k % 4)][7:4]} ^ flip, "user");
        $display("test user done");
    endtask
    task automatic t_pn();
        int chg;
        logic [22:0] pn_ref;
        chg = 0;
        pn_ref = `OTP_PN_SEED;
        set_fmt(1'b0);
        mode(otp_pkg::OTP_PN);
        for (int i = 0; i < 8; i++) begin
            smp(12'h5A5, 12'h000, "pn", 1'b0);
            pn_a[i] = out_data;
            cmp_word("pn model", pn_ref[11:0], out_data);
            pn_ref = {pn_ref[21:0], pn_ref[`OTP_PN_TAP_A] ^ pn_ref[`OTP_PN_TAP_B]};
            if (i > 0 && pn_a[i] !== pn_a[i - 1]) chg++;
        end
        cmp_byte("pn varies", 8'h01, {7'h00, chg > 4});
        // a mode write restarts the sequence, so run two must repeat run one
        set_fmt(1'b1);
        mode(otp_pkg::OTP_PN);
        for (int i = 0; i < 8; i++) smp(12'h5A5, pn_a[i] ^ flip, "pn formatted");
        $display("test pn done");
    endtask
    task automatic t_unlisted();
        logic [3:0] codes [7];
        codes = '{4'h6, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
        set_fmt(1'b1);
        for (int c = 0; c < 7; c++) begin
            wr(`OTP_ADDR_MODE, {4'h0, codes[c]});
            smp(12'h2B7 + 12'(c), (12'h2B7 + 12'(c)) ^ flip, "unlisted");
        end
        $display("test unlisted done");
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // watchdog: the whole run is a few hundred cycles
    initial begin
        repeat (50000) @(posedge core_clk);
        err_count++;
        results();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_fixed();
        t_alt();
        t_ramp();
        t_user();
        t_pn();
        t_unlisted();
        // the receiver takes the last word one edge after it is shown
        @(posedge core_clk);
        #1 cmp_word("rx count", 12'(n_sent), rx_count[11:0]);
        cmp_word("rx last", 12'hABD, rx_last);
        results();
    end
endmodule
